// [pkg/nav_codec_cfg.svh]
// constants for the navigation-state payload decoder
`ifndef NAV_CODEC_CFG_SVH
`define NAV_CODEC_CFG_SVH

// ----------------------------------------------------------------------
// packet identifiers
// ----------------------------------------------------------------------
`define ID_GEODETIC 8'h20
`define ID_ECEF 8'h21
`define ID_UTM 8'h22
`define ID_NED_VEL 8'h23
`define ID_BODY_VEL 8'h24
`define ID_ACCEL 8'h25
`define ID_BODY_ACCEL 8'h26
`define ID_EULER 8'h27
`define ID_QUAT 8'h28
`define ID_ROT_MATRIX 8'h29

// ----------------------------------------------------------------------
// payload lengths in bytes
// ----------------------------------------------------------------------
`define LEN_GEODETIC 8'h18
`define LEN_ECEF 8'h18
`define LEN_UTM 8'h1a
`define LEN_NED_VEL 8'h0c
`define LEN_BODY_VEL 8'h0c
`define LEN_ACCEL 8'h0c
`define LEN_BODY_ACCEL 8'h10
`define LEN_EULER 8'h0c
`define LEN_QUAT 8'h10
`define LEN_ROT_MATRIX 8'h24
`define LEN_NONE 8'h00

// ----------------------------------------------------------------------
// field sizes and offsets
// ----------------------------------------------------------------------
`define FP64_BYTES 4'h8
`define FP32_BYTES 4'h4
`define INT8_BYTES 4'h1
`define UTM_ZONE_NUM_OFS 8'h18
`define UTM_ZONE_LETTER_OFS 8'h19

// ----------------------------------------------------------------------
// satellite frequency mask bit positions
// ----------------------------------------------------------------------
`define FREQ_L1_LSB 0
`define FREQ_L1_MSB 3
`define FREQ_L2_LSB 4
`define FREQ_L2_MSB 6
`define FREQ_L5_BIT 7

`endif

// [pkg/nav_codec_pkg.sv]
// types shared by the navigation-state payload decoder
package nav_codec_pkg;
    typedef enum logic [1:0] {
        st_idle,
        st_payload,
        st_discard
    } parse_state_t;
    typedef logic [7:0] byte_t;
endpackage

// [verilog/field_buffer.sv]
// two-entry shift buffer for decoded fields, valid/ready on both sides
`timescale 1ns/1ps
module field_buffer #(
    parameter int WIDTH = 76,
    parameter int DEPTH = 2
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // fill side
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    output logic nxt_ready_o,
    // drain side
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    logic [DEPTH-1:0] vld_ff;
    logic [WIDTH-1:0] data_ff [DEPTH];
    logic push;
    logic pop;
    logic [DEPTH:0] cnt;
    logic [DEPTH:0] cnt_after_pop;
    logic [DEPTH-1:0] nxt_vld;

    assign in_ready_o = ~vld_ff[DEPTH-1];
    assign out_valid_o = vld_ff[0];
    assign out_data_o = data_ff[0];
    assign push = in_valid_i & in_ready_o;
    assign pop = vld_ff[0] & out_ready_i;
    assign nxt_ready_o = ~nxt_vld[DEPTH-1];

    always_comb begin
        cnt = '0;
        for (int i = 0; i < DEPTH; i++) begin
            cnt = cnt + {{DEPTH{1'b0}}, vld_ff[i]};
        end
        cnt_after_pop = cnt - {{DEPTH{1'b0}}, pop};
    end

    // ------------------------------------------------------------------
    // entries
    // ------------------------------------------------------------------
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        localparam logic [DEPTH:0] IDX = (DEPTH+1)'(i);
        assign nxt_vld[i] = (IDX < cnt_after_pop) ||
                            (push && IDX == cnt_after_pop);
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                vld_ff[i] <= 1'b0;
                data_ff[i] <= '0;
            end else begin
                vld_ff[i] <= nxt_vld[i];
                if (push && IDX == cnt_after_pop) begin
                    data_ff[i] <= in_data_i;
                end else if (pop) begin
                    if (i + 1 < DEPTH) begin
                        data_ff[i] <= data_ff[(i + 1) % DEPTH];
                    end
                end
            end
        end
    end
endmodule

// [verilog/nav_state_packet_payload_codec.sv]
// decoder for navigation-state packet payloads into typed field words
//
// Contract
// RL1: frequency byte: L1 bits 0-3, L2 4-6, L5 7
// RL2: id 32: 24 bytes, lat/lon/height doubles
// RL3: id 33: 24 bytes, ECEF X/Y/Z doubles
// RL4: id 34: 26 bytes, northing/easting/height doubles first
// RL5: UTM zone number byte 24, letter signed 25
// RL6: id 35: 12 bytes, NED velocity singles
// RL7: id 36: 12 bytes, body velocity singles
// RL8: id 37: 12 bytes, acceleration XYZ singles
// RL9: id 38: 16 bytes, body accel plus g-force
// RL10: id 39: 12 bytes, roll/pitch/heading singles
// RL11: id 40: 16 bytes, scalar then X/Y/Z
// RL12: id 41: 36 bytes, nine matrix singles row-major
// RL13: wrong declared length rejected, no field output
`timescale 1ns/1ps
`include "nav_codec_cfg.svh"
module nav_state_packet_payload_codec #(
    parameter int BUF_DEPTH = 2
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // packet header from framing logic
    input wire logic hdr_valid_i,
    input wire nav_codec_pkg::byte_t hdr_id_i,
    input wire nav_codec_pkg::byte_t hdr_len_i,
    output logic hdr_ready_o,
    // payload byte stream
    input wire logic byte_valid_i,
    input wire nav_codec_pkg::byte_t byte_data_i,
    output logic byte_ready_o,
    // decoded field words
    output logic fld_valid_o,
    output nav_codec_pkg::byte_t fld_pkt_id_o,
    output logic [3:0] fld_index_o,
    output logic [63:0] fld_data_o,
    input wire logic fld_ready_i,
    // packet status pulses
    output logic pkt_done_o,
    output logic pkt_reject_o,
    // satellite frequency mask decode
    input wire logic sat_freq_valid_i,
    input wire nav_codec_pkg::byte_t sat_freq_i,
    output logic [3:0] l1_sig_o,
    output logic [2:0] l2_sig_o,
    output logic l5_sig_o
);
    import nav_codec_pkg::*;

    localparam int FLD_W = 76;

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    function automatic byte_t expected_len(input byte_t id);
        case (id)
            `ID_GEODETIC: expected_len = `LEN_GEODETIC; // RL2
            `ID_ECEF: expected_len = `LEN_ECEF; // RL3
            `ID_UTM: expected_len = `LEN_UTM; // RL4
            `ID_NED_VEL: expected_len = `LEN_NED_VEL; // RL6
            `ID_BODY_VEL: expected_len = `LEN_BODY_VEL; // RL7
            `ID_ACCEL: expected_len = `LEN_ACCEL; // RL8
            `ID_BODY_ACCEL: expected_len = `LEN_BODY_ACCEL; // RL9
            `ID_EULER: expected_len = `LEN_EULER; // RL10
            `ID_QUAT: expected_len = `LEN_QUAT; // RL11
            `ID_ROT_MATRIX: expected_len = `LEN_ROT_MATRIX; // RL12
            default: expected_len = `LEN_NONE;
        endcase
    endfunction

    // width of the field that holds payload byte ofs
    function automatic logic [3:0] field_bytes(input byte_t id,
                                               input byte_t ofs);
        if (id == `ID_GEODETIC || id == `ID_ECEF) begin
            field_bytes = `FP64_BYTES; // RL2 RL3
        end else if (id == `ID_UTM) begin
            field_bytes = (ofs < `UTM_ZONE_NUM_OFS) ? `FP64_BYTES
                                                     : `INT8_BYTES; // RL5
        end else begin
            field_bytes = `FP32_BYTES;
        end
    endfunction

    // ------------------------------------------------------------------
    // parser state
    // ------------------------------------------------------------------
    parse_state_t state_ff;
    parse_state_t nxt_state;
    byte_t id_ff;
    byte_t left_ff;
    byte_t ofs_ff;
    logic [2:0] bcnt_ff;
    logic [3:0] idx_ff;
    logic [63:0] acc_ff;
    logic [63:0] nxt_acc;
    logic hdr_ready_ff;
    logic byte_ready_ff;
    logic done_ff;
    logic reject_ff;
    logic [3:0] l1_ff;
    logic [2:0] l2_ff;
    logic l5_ff;
    logic hdr_take;
    logic byte_take;
    logic known;
    logic len_ok;
    logic last_of_field;
    logic push;
    logic [63:0] push_data;
    logic buf_nxt_ready;
    logic buf_ready;

    assign hdr_take = hdr_valid_i & hdr_ready_ff;
    assign byte_take = byte_valid_i & byte_ready_ff;
    assign known = expected_len(hdr_id_i) != `LEN_NONE;
    assign len_ok = known && hdr_len_i == expected_len(hdr_id_i); // RL13
    assign last_of_field =
        {1'b0, bcnt_ff} == field_bytes(id_ff, ofs_ff) - 4'h1;
    assign push = byte_take && state_ff == st_payload && last_of_field;

    always_comb begin
        nxt_acc = (bcnt_ff == 3'h0) ? 64'h0 : acc_ff;
        nxt_acc[{bcnt_ff, 3'h0} +: 8] = byte_data_i;
        push_data = nxt_acc;
        // zone letter is a signed byte, so it widens with its sign
        if (id_ff == `ID_UTM && ofs_ff == `UTM_ZONE_LETTER_OFS) begin
            push_data = {{56{byte_data_i[7]}}, byte_data_i}; // RL5
        end
    end

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            st_idle: begin
                if (hdr_take) begin
                    if (hdr_len_i == `LEN_NONE) begin
                        nxt_state = st_idle;
                    end else if (len_ok) begin
                        nxt_state = st_payload;
                    end else begin
                        nxt_state = st_discard; // RL13
                    end
                end
            end
            st_payload, st_discard: begin
                if (byte_take && left_ff == 8'h01) begin
                    nxt_state = st_idle;
                end
            end
            default: nxt_state = st_idle;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff <= st_idle;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ready flags are registered so the ports come from flops
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hdr_ready_ff <= 1'b0;
            byte_ready_ff <= 1'b0;
        end else begin
            hdr_ready_ff <= nxt_state == st_idle;
            byte_ready_ff <= nxt_state != st_idle && buf_nxt_ready;
        end
    end

    // ------------------------------------------------------------------
    // payload counters and field assembly, little-endian
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            id_ff <= 8'h00;
            left_ff <= 8'h00;
            ofs_ff <= 8'h00;
            bcnt_ff <= 3'h0;
            idx_ff <= 4'h0;
            acc_ff <= 64'h0;
        end else if (hdr_take) begin
            id_ff <= hdr_id_i;
            left_ff <= hdr_len_i;
            ofs_ff <= 8'h00;
            bcnt_ff <= 3'h0;
            idx_ff <= 4'h0;
        end else if (byte_take) begin
            left_ff <= left_ff - 8'h01;
            ofs_ff <= ofs_ff + 8'h01;
            acc_ff <= nxt_acc;
            bcnt_ff <= last_of_field ? 3'h0 : bcnt_ff + 3'h1;
            if (push) begin
                idx_ff <= idx_ff + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // status pulses
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done_ff <= 1'b0;
            reject_ff <= 1'b0;
        end else begin
            done_ff <= byte_take && state_ff == st_payload &&
                       left_ff == 8'h01;
            reject_ff <= hdr_take && known && !len_ok; // RL13
        end
    end

    // ------------------------------------------------------------------
    // satellite frequency mask
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            l1_ff <= 4'h0;
            l2_ff <= 3'h0;
            l5_ff <= 1'b0;
        end else if (sat_freq_valid_i) begin
            l1_ff <= sat_freq_i[`FREQ_L1_MSB:`FREQ_L1_LSB]; // RL1
            l2_ff <= sat_freq_i[`FREQ_L2_MSB:`FREQ_L2_LSB]; // RL1
            l5_ff <= sat_freq_i[`FREQ_L5_BIT]; // RL1
        end
    end

    // ------------------------------------------------------------------
    // output buffer; a stalled consumer drops byte_ready_o
    // ------------------------------------------------------------------
    field_buffer #(
        .WIDTH(FLD_W),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(push),
        .in_data_i({id_ff, idx_ff, push_data}),
        .in_ready_o(buf_ready),
        .nxt_ready_o(buf_nxt_ready),
        .out_valid_o(fld_valid_o),
        .out_data_o({fld_pkt_id_o, fld_index_o, fld_data_o}),
        .out_ready_i(fld_ready_i)
    );

    assign hdr_ready_o = hdr_ready_ff;
    assign byte_ready_o = byte_ready_ff;
    assign pkt_done_o = done_ff;
    assign pkt_reject_o = reject_ff;
    assign l1_sig_o = l1_ff;
    assign l2_sig_o = l2_ff;
    assign l5_sig_o = l5_ff;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_freq_decode: assert property (sat_freq_valid_i |=> // RL1
        l1_sig_o == $past(sat_freq_i[3:0]) &&
        l2_sig_o == $past(sat_freq_i[6:4]) && l5_sig_o == $past(sat_freq_i[7]))
        else $error("frequency mask decode wrong");
    chk_geo_len: assert property (hdr_take && hdr_id_i == 8'h20 && // RL2
        hdr_len_i == 8'h18 |=> state_ff == st_payload && left_ff == 8'h18)
        else $error("geodetic header not accepted");
    chk_ecef_width: assert property (push && id_ff == 8'h21 |-> // RL3
        ofs_ff[2:0] == 3'h7 && idx_ff <= 4'h2)
        else $error("ecef field not eight bytes");
    chk_utm_len: assert property (hdr_take && hdr_id_i == 8'h22 && // RL4
        hdr_len_i == 8'h1a |=> state_ff == st_payload)
        else $error("utm header not accepted");
    chk_utm_letter: assert property (push && id_ff == 8'h22 && // RL5
        ofs_ff == 8'h19 |-> idx_ff == 4'h4 &&
        push_data[63:7] == {57{byte_data_i[7]}})
        else $error("utm zone letter not sign extended");
    chk_ned_len: assert property (hdr_take && hdr_id_i == 8'h23 && // RL6
        hdr_len_i != 8'h0c |=> pkt_reject_o)
        else $error("ned bad length accepted");
    chk_bvel_len: assert property (hdr_take && hdr_id_i == 8'h24 && // RL7
        hdr_len_i == 8'h0c |=> left_ff == 8'h0c)
        else $error("body velocity length wrong");
    chk_accel_width: assert property (push && id_ff == 8'h25 |-> // RL8
        ofs_ff[1:0] == 2'h3 && push_data[63:32] == 32'h0)
        else $error("acceleration field not four bytes");
    chk_gforce_last: assert property (push && id_ff == 8'h26 && // RL9
        idx_ff == 4'h3 |=> pkt_done_o)
        else $error("g-force not the last field");
    chk_euler_len: assert property (hdr_take && hdr_id_i == 8'h27 && // RL10
        hdr_len_i == 8'h0c |=> state_ff == st_payload)
        else $error("euler header not accepted");
    chk_quat_count: assert property (push && id_ff == 8'h28 |-> // RL11
        idx_ff <= 4'h3)
        else $error("too many quaternion fields");
    chk_matrix_end: assert property (push && id_ff == 8'h29 && // RL12
        ofs_ff == 8'h23 |-> idx_ff == 4'h8)
        else $error("matrix element count wrong");
    chk_reject_drop: assert property (hdr_take && known && !len_ok |=> // RL13
        pkt_reject_o && state_ff != st_payload && !push)
        else $error("bad length packet not rejected");
endmodule

// [testbench/field_sink.sv]
// consumer model for decoded field words, with selectable stalling
`timescale 1ns/1ps
module field_sink (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // field stream
    input wire logic fld_valid_i,
    input wire nav_codec_pkg::byte_t fld_pkt_id_i,
    input wire logic [3:0] fld_index_i,
    input wire logic [63:0] fld_data_i,
    output logic fld_ready_o,
    // stall chance in percent, 0 never stalls
    input wire logic [6:0] stall_i
);
    import nav_codec_pkg::*;
    logic [75:0] got[$];
    initial fld_ready_o = 1'b0;
    // ready moves on the falling edge only, so taking edges are clean
    always @(negedge clk_i) begin
        fld_ready_o <= rst_n_i && ($urandom_range(99) >= stall_i);
    end
    always @(posedge clk_i) begin
        if (fld_valid_i === 1'b1 && fld_ready_o === 1'b1) begin
            got.push_back({fld_pkt_id_i, fld_index_i, fld_data_i});
        end
    end
endmodule

// [testbench/test_nav_state_packet_payload_codec.sv]
// self-checking bench for the navigation-state payload decoder
`timescale 1ns/1ps
`include "nav_codec_cfg.svh"
module test_nav_state_packet_payload_codec;
    import nav_codec_pkg::*;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic hdr_valid_i = 1'b0;
    byte_t hdr_id_i = 8'h00;
    byte_t hdr_len_i = 8'h00;
    logic byte_valid_i = 1'b0;
    byte_t byte_data_i = 8'h00;
    logic sat_freq_valid_i = 1'b0;
    byte_t sat_freq_i = 8'h00;
    logic [6:0] stall = 7'h00;
    logic hdr_ready_o, byte_ready_o, fld_valid_o, fld_ready;
    byte_t fld_pkt_id_o;
    logic [3:0] fld_index_o;
    logic [63:0] fld_data_o;
    logic pkt_done_o, pkt_reject_o;
    logic [3:0] l1_sig_o;
    logic [2:0] l2_sig_o;
    logic l5_sig_o;
    int bad_count = 0;
    int checks = 0;
    int done_n = 0;
    int rej_n = 0;
    int done_exp = 0;
    byte_t pay [0:63];
    logic [75:0] exp_q[$];
    logic [75:0] seen;
    logic [75:0] want;
    logic [7:0] m;

    nav_state_packet_payload_codec DUT (
        .clk_i(clk_i), .rst_n_i(rst_n_i),
        .hdr_valid_i(hdr_valid_i), .hdr_id_i(hdr_id_i),
        .hdr_len_i(hdr_len_i), .hdr_ready_o(hdr_ready_o),
        .byte_valid_i(byte_valid_i), .byte_data_i(byte_data_i),
        .byte_ready_o(byte_ready_o),
        .fld_valid_o(fld_valid_o), .fld_pkt_id_o(fld_pkt_id_o),
        .fld_index_o(fld_index_o), .fld_data_o(fld_data_o),
        .fld_ready_i(fld_ready),
        .pkt_done_o(pkt_done_o), .pkt_reject_o(pkt_reject_o),
        .sat_freq_valid_i(sat_freq_valid_i), .sat_freq_i(sat_freq_i),
        .l1_sig_o(l1_sig_o), .l2_sig_o(l2_sig_o), .l5_sig_o(l5_sig_o)
    );
    field_sink sink (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .fld_valid_i(fld_valid_o),
        .fld_pkt_id_i(fld_pkt_id_o), .fld_index_i(fld_index_o),
        .fld_data_i(fld_data_o), .fld_ready_o(fld_ready),
        .stall_i(stall)
    );

    initial forever #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (pkt_done_o === 1'b1) done_n++;
        if (pkt_reject_o === 1'b1) rej_n++;
    end
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic check(input string name, input logic [75:0] s,
                         input logic [75:0] e);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, e, s);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    function automatic byte_t len_of(input byte_t id);
        case (id)
            `ID_GEODETIC, `ID_ECEF: return `LEN_GEODETIC;
            `ID_UTM: return `LEN_UTM;
            `ID_BODY_ACCEL, `ID_QUAT: return `LEN_QUAT;
            `ID_ROT_MATRIX: return `LEN_ROT_MATRIX;
            `ID_NED_VEL, `ID_BODY_VEL, `ID_ACCEL, `ID_EULER: return 8'h0c;
            default: return `LEN_NONE;
        endcase
    endfunction
    // expected words: doubles for 32..34, two UTM zone bytes, else singles
    task automatic build_exp(input byte_t id);
        int nf, sz, ofs;
        logic [63:0] d;
        nf = (id < 8'h22) ? 3 : (id == 8'h22) ? 5 : len_of(id) / 4;
        for (int i = 0; i < nf; i++) begin
            sz = (id < 8'h23) ? ((i < 3) ? 8 : 1) : 4;
            ofs = (sz == 8) ? i * 8 : (sz == 1) ? 21 + i : i * 4;
            d = 64'h0;
            for (int k = 0; k < sz; k++) d[8*k +: 8] = pay[ofs + k];
            if (id == 8'h22 && i == 4) d = {{56{pay[25][7]}}, pay[25]};
            exp_q.push_back({id, i[3:0], d});
        end
        done_exp++;
    endtask
    // called on a falling edge; request held until ready at the edge
    task automatic send_pkt(input byte_t id, input byte_t len, input int nb);
        int n;
        n = 0;
        hdr_id_i = id;
        hdr_len_i = len;
        hdr_valid_i = 1'b1;
        while (hdr_ready_o !== 1'b1 && n < 800) begin
            @(negedge clk_i);
            n++;
        end
        @(negedge clk_i);
        hdr_valid_i = 1'b0;
        for (int i = 0; i < nb; i++) begin
            byte_data_i = pay[i];
            byte_valid_i = 1'b1;
            while (byte_ready_o !== 1'b1 && n < 800) begin
                @(negedge clk_i);
                n++;
            end
            @(negedge clk_i);
        end
        byte_valid_i = 1'b0;
        if (n >= 800) begin
            bad_count++;
            end_sim();
        end
    endtask
    task automatic drain_check();
        int n;
        n = 0;
        while (sink.got.size() < exp_q.size() && n < 800) begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 800) begin
            bad_count++;
            end_sim();
        end else begin
            while (exp_q.size() > 0) begin
                want = exp_q.pop_front();
                seen = sink.got.pop_front();
                if (want[75:68] < `ID_NED_VEL) begin
                    check("position", seen, want);
                end else if (want[75:68] < `ID_EULER) begin
                    check("motion", seen, want);
                end else begin
                    check("attitude", seen, want);
                end
            end
        end
    endtask
    task automatic fill_pay();
        for (int i = 0; i < 64; i++) pay[i] = 8'($urandom_range(255));
    endtask
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        #100000;
        bad_count++;
        end_sim();
    end
    initial begin
        void'($urandom(32'h6d4a));
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        rst_n_i = 1'b1;
        stall = 7'h1e;
        for (int id = 32; id <= 41; id++) begin
            fill_pay();
            build_exp(id[7:0]);
            send_pkt(id[7:0], len_of(id[7:0]), len_of(id[7:0]));
            drain_check();
        end
        $display("test all layouts done");
        // sign corner of the zone letter, and a heavy stall on 14 fields
        stall = 7'h5a;
        fill_pay();
        pay[24] = 8'hff;
        pay[25] = 8'h80;
        build_exp(`ID_UTM);
        build_exp(`ID_ROT_MATRIX);
        send_pkt(`ID_UTM, `LEN_UTM, 26);
        send_pkt(`ID_ROT_MATRIX, `LEN_ROT_MATRIX, 36);
        drain_check();
        $display("test zone sign and stall done");
        stall = 7'h00;
        send_pkt(`ID_NED_VEL, `LEN_QUAT, 16);
        send_pkt(8'h2a, 8'h05, 5);
        // a known id that declares no payload is a wrong length too
        send_pkt(`ID_EULER, `LEN_NONE, 0);
        repeat (20) @(negedge clk_i);
        check("reject", rej_n, 2);
        check("words", sink.got.size(), 0);
        check("done", done_n, done_exp);
        $display("test wrong length done");
        // strobe held high so each mask loads on the next edge
        sat_freq_valid_i = 1'b1;
        for (int i = 0; i < 12; i++) begin
            m = (i < 8) ? (8'h01 << i) : 8'($urandom_range(255));
            sat_freq_i = m;
            @(negedge clk_i);
            check("freq", {l5_sig_o, l2_sig_o, l1_sig_o}, m);
        end
        sat_freq_valid_i = 1'b0;
        $display("test frequency mask done");
        end_sim();
    end
endmodule
